//--- rtl/scp_pkg.sv
// Package of constants and types for the system clock prescaler block
package scp_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_PRESCALE_OFS = 4'h0; // clock_prescale_control
    localparam logic [3:0] REG_STATUS_OFS = 4'h4; // Divider state, read only
    localparam logic [3:0] REG_PINCFG_OFS = 4'h8; // Timer osc and ext clock
    localparam int unsigned PCE_BIT = 7;
    localparam int unsigned SEL_MSB = 3;
    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [3:0] SEL_RESET_FUSE_OFF = 4'h0;
    localparam logic [3:0] SEL_RESET_FUSE_ON = 4'h3;
    localparam logic [3:0] SEL_MAX_LEGAL = 4'h8;
    localparam logic [2:0] PCE_WINDOW_CYCLES = 3'h4;
    localparam int unsigned DIV_W = 9;
    // ------------------------------------------------------------------
    // Clock source choices seen by the timer oscillator gate
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_EXTERNAL = 2'b00,
        SRC_CRYSTAL = 2'b01,
        SRC_RC_CAL = 2'b10,
        SRC_RC_LOW = 2'b11
    } scp_src_e;
endpackage

//--- rtl/scp_div_if.sv
// Interface between the register front end and the divider core
`timescale 1ns/1ps
interface scp_div_if;
    logic [3:0] sel;
    logic load;
    logic clk_en;
    logic [3:0] active_sel;
    modport ctrl (output sel, output load, input clk_en, input active_sel);
    modport core (input sel, input load, output clk_en, output active_sel);
endinterface // scp_div_if

//--- rtl/scp_divider.sv
// Glitch-free power-of-two divider producing a one-cycle clock enable
`timescale 1ns/1ps
module scp_divider (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [3:0] reset_sel_in,
    scp_div_if.core div
);
    typedef struct packed {
        logic [scp_pkg::DIV_W-1:0] cnt;
        logic [3:0] cur;
        logic [3:0] pend;
        logic pend_v;
        logic en;
    } scp_div_s;
    scp_div_s s_q;
    scp_div_s s_d;
    logic [scp_pkg::DIV_W-1:0] last;

    // --------------------------------------------------------------
    // Divider state
    // --------------------------------------------------------------
    // Terminal count for the active factor; new factor only at a boundary,
    // so each period is fully old or fully new and never shorter.
    always_comb begin
        last = scp_pkg::DIV_W'((10'h001 << s_q.cur) - 10'h001);
        s_d = s_q;
        s_d.en = 1'b0;
        if (div.load) begin
            s_d.pend = div.sel;
            s_d.pend_v = 1'b1;
        end
        if (s_q.cnt >= last) begin
            s_d.cnt = '0;
            s_d.en = 1'b1;
            if (s_q.pend_v) begin
                s_d.cur = s_q.pend;
                s_d.pend_v = div.load;
            end
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    // Registers the state; the reset factor follows the fuse
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q <= '0;
            s_q.cur <= reset_sel_in;
        end else if (ce_in) begin
            s_q <= s_d;
        end
    end

    assign div.clk_en = s_q.en;
    assign div.active_sel = s_q.cur;
endmodule // scp_divider

//--- rtl/scp_top.sv
// System clock prescaler with protected register and clock output pin
//
// Notes on behaviour
// - programmed clock-output fuse puts the system clock on the output pin.
// - with that fuse, the pin stays enabled during reset but is held low, as the divider enable is cleared.
// - the pin carries the divided clock from whatever source is selected.
// - timer oscillator allowed on crystal pins only with an RC system source.
// - one divided enable slows I/O, ADC, CPU and flash clocks together.
// - changing the factor never glitches the divided clocks.
// - no intermediate period is shorter than both old and new periods.
// - new factor active from the next divider boundary, at most about one old period after the write.
// - divider counts at the undivided clock; its count is not readable.
// - change-enable updates only when all other bits are written zero.
// - change-enable self-clears after four cycles or when the factor is written.
// - rewriting change-enable inside the window neither extends nor clears it.
// - reset loads select 0000, or 0011 with the divide-by-eight fuse.
// - any legal select value (0 to 8) is accepted regardless of the divide-by-eight fuse.
// - select n divides by two to the n, up to 256; higher codes reserved.
`timescale 1ns/1ps
module scp_top (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic clk_enable_in,
    input wire logic clock_output_fuse_in,
    input wire logic divide_by_eight_fuse_in,
    input wire logic [1:0] clock_source_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic sys_clk_en_out,
    output logic clock_output_pin_out,
    output logic clock_output_pin_oe_out,
    output logic timer_osc_enable_out,
    output logic timer_ext_clock_select_out
);
    typedef struct packed {
        logic [1:0] fuse_sync;
        logic [1:0] fuse_meta;
        logic pce;
        logic [2:0] pce_cnt;
        logic [3:0] sel;
        logic load;
        logic ack;
        logic [31:0] rdata;
        logic sys_en;
        logic pin;
        logic pin_oe;
        logic tosc_req;
        logic ext_sel;
        logic tosc_en;
    } scp_top_s;

    scp_top_s s_q;
    scp_top_s s_d;
    scp_div_if div ();
    logic [3:0] reset_sel;
    logic is_rc;
    logic wr_hit;
    logic rd_hit;

    // ------------------------------------------------------------------
    // Divider core
    // ------------------------------------------------------------------
    // Reset factor chosen by the synchronised divide-by-eight fuse
    // Bit 0 of the synchroniser carries that fuse; bit 1 is the clock-output fuse
    assign reset_sel = s_q.fuse_sync[0] ? scp_pkg::SEL_RESET_FUSE_ON
                                        : scp_pkg::SEL_RESET_FUSE_OFF;

    scp_divider u_div (
        .clk_in(ref_clk_in),
        .rst_in(reset_in),
        .ce_in(clk_enable_in),
        .reset_sel_in(reset_sel),
        .div(div.core)
    );

    assign div.sel = s_q.sel;
    assign div.load = s_q.load;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // One wait cycle per access: the answer comes on the second edge
    assign wr_hit = avs_write_in && !s_q.ack;
    assign rd_hit = avs_read_in && !s_q.ack;
    assign is_rc = (clock_source_in == scp_pkg::SRC_RC_CAL)
                || (clock_source_in == scp_pkg::SRC_RC_LOW);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.fuse_meta = {clock_output_fuse_in, divide_by_eight_fuse_in};
        s_d.fuse_sync = s_q.fuse_meta;
        s_d.load = 1'b0;
        s_d.ack = wr_hit || rd_hit;
        // Change-enable window counts down and closes by itself
        if (s_q.pce) begin
            if (s_q.pce_cnt <= 3'h1) begin
                s_d.pce = 1'b0;
                s_d.pce_cnt = 3'h0;
            end else begin
                s_d.pce_cnt = s_q.pce_cnt - 3'h1;
            end
        end
        if (wr_hit && avs_byteenable_in[0]) begin
            case (avs_address_in)
                scp_pkg::REG_PRESCALE_OFS: begin
                    if (avs_writedata_in[7:0] == 8'h80) begin
                        // Rewrite while open leaves the window untouched
                        if (!s_q.pce) begin
                            s_d.pce = 1'b1;
                            s_d.pce_cnt = scp_pkg::PCE_WINDOW_CYCLES;
                        end
                    end else if (s_q.pce && !avs_writedata_in[scp_pkg::PCE_BIT]) begin
                        s_d.pce = 1'b0;
                        s_d.pce_cnt = 3'h0;
                        // Reserved codes are dropped: the old factor stays
                        if (avs_writedata_in[3:0] <= scp_pkg::SEL_MAX_LEGAL) begin
                            s_d.sel = avs_writedata_in[scp_pkg::SEL_MSB:0];
                            s_d.load = 1'b1;
                        end
                    end
                end
                scp_pkg::REG_PINCFG_OFS: begin
                    s_d.tosc_req = avs_writedata_in[0];
                    s_d.ext_sel = avs_writedata_in[1];
                end
                default: begin
                end
            endcase
        end
        // Read data; bits six to four are held at zero
        if (rd_hit) begin
            case (avs_address_in)
                scp_pkg::REG_PRESCALE_OFS:
                    s_d.rdata = {24'h000000, s_q.pce, 3'h0, s_q.sel};
                scp_pkg::REG_STATUS_OFS:
                    s_d.rdata = {28'h0000000, div.active_sel};
                scp_pkg::REG_PINCFG_OFS:
                    s_d.rdata = {29'h00000000, s_q.tosc_en, s_q.ext_sel, s_q.tosc_req};
                default:
                    s_d.rdata = 32'h00000000;
            endcase
        end
        // Timer oscillator only while an RC oscillator clocks the system
        s_d.tosc_en = s_q.tosc_req && is_rc;
        s_d.sys_en = div.clk_en;
        // Pin shows a divided clock: high on the enable cycle
        s_d.pin = div.clk_en;
        s_d.pin_oe = s_q.fuse_sync[1];
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Fuse synchronisers and pin drive keep running through reset
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            s_q.pce <= 1'b0;
            s_q.pce_cnt <= 3'h0;
            s_q.sel <= reset_sel;
            s_q.load <= 1'b0;
            s_q.ack <= 1'b0;
            s_q.rdata <= 32'h00000000;
            s_q.sys_en <= 1'b0;
            s_q.tosc_req <= 1'b0;
            s_q.ext_sel <= 1'b0;
            s_q.tosc_en <= 1'b0;
            s_q.fuse_meta <= s_d.fuse_meta;
            s_q.fuse_sync <= s_d.fuse_sync;
            s_q.pin <= s_d.pin;
            s_q.pin_oe <= s_d.pin_oe;
        end else if (clk_enable_in) begin
            s_q <= s_d;
        end
    end

    assign avs_readdata_out = s_q.rdata;
    assign avs_waitrequest_out = !s_q.ack;
    assign sys_clk_en_out = s_q.sys_en;
    assign clock_output_pin_out = s_q.pin;
    assign clock_output_pin_oe_out = s_q.pin_oe;
    assign timer_osc_enable_out = s_q.tosc_en;
    assign timer_ext_clock_select_out = s_q.ext_sel;
endmodule // scp_top

//--- tb/scp_checker.sv
// Concurrent checks on the prescaler top ports
`timescale 1ns/1ps
module scp_checker (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic clk_enable_in,
    input wire logic clock_output_fuse_in,
    input wire logic [1:0] clock_source_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic clock_output_pin_oe_out,
    input wire logic timer_osc_enable_out,
    input wire logic timer_ext_clock_select_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    // Pin config write completing at this edge, with the ext select bit given
    sequence s_cfg_wr(bit v);
        clk_enable_in && avs_write_in && avs_address_in == 4'h8 && avs_byteenable_in[0]
            && !avs_waitrequest_out && avs_writedata_in[1] == v;
    endsequence
    // Fuse level settles through two synchroniser flops before the pin follows
    AST_OE_ON: assert property (clock_output_fuse_in [*5] |-> clock_output_pin_oe_out)
        else $error("clock output not enabled by fuse");
    AST_OE_OFF: assert property (!clock_output_fuse_in [*5] |-> !clock_output_pin_oe_out)
        else $error("clock output enabled without fuse");
    AST_TIMER_OSC: assert property (timer_osc_enable_out |-> $past(clock_source_in[1]))
        else $error("timer osc enabled without RC source");
    AST_EXT_SET: assert property (s_cfg_wr(1'h1) |=> ##[0:2] timer_ext_clock_select_out)
        else $error("ext clock select not set");
    AST_EXT_CLR: assert property (s_cfg_wr(1'h0) |=> ##[0:2] !timer_ext_clock_select_out)
        else $error("ext clock select not cleared");
    AST_WAIT_ANSWER: assert property ((avs_read_in || avs_write_in) && clk_enable_in
        && !$past(avs_read_in || avs_write_in) |=> !avs_waitrequest_out)
        else $error("bus answer late");
    AST_WAIT_ONE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    AST_RDATA_HOLD: assert property (!avs_read_in && !$past(avs_read_in)
        |-> $stable(avs_readdata_out)) else $error("read data moved without a read");
endmodule // scp_checker
bind scp_top scp_checker scp_checker_inst (.*);

//--- tb/tb.sv
// Self-checking bench for the system clock prescaler
`timescale 1ns/1ps
module tb;
    logic ref_clk_in = 1'h0;
    logic reset_in = 1'h1;
    logic clk_enable_in = 1'h1;
    logic clock_output_fuse_in = 1'h0;
    logic divide_by_eight_fuse_in = 1'h0;
    logic [1:0] clock_source_in = 2'h0;
    logic [3:0] avs_address_in = 4'h0;
    logic avs_read_in = 1'h0;
    logic avs_write_in = 1'h0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0] avs_byteenable_in = 4'hF;
    logic [31:0] avs_readdata_out, rd;
    logic avs_waitrequest_out, sys_clk_en_out, clock_output_pin_out;
    logic clock_output_pin_oe_out, timer_osc_enable_out, timer_ext_clock_select_out;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int p, prev;
    scp_top scp_top_inst (.*);
    // 50 MHz master clock
    initial forever #10 ref_clk_in = ~ref_clk_in;
    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus access; waits for waitrequest low however long it takes
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        avs_write_in <= w;
        avs_read_in <= !w;
        avs_address_in <= a;
        avs_writedata_in <= {24'h0, d};
        do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'h0);
        rd = avs_readdata_out;
        avs_write_in <= 1'h0;
        avs_read_in <= 1'h0;
        @(posedge ref_clk_in);
    endtask
    // Cycles between two divided pulses, on the enable or on the pin
    task automatic period(input bit pin, output int n);
        n = 0;
        do @(posedge ref_clk_in); while ((pin ? clock_output_pin_out : sys_clk_en_out) !== 1'h1);
        do begin
            @(posedge ref_clk_in);
            n++;
        end while ((pin ? clock_output_pin_out : sys_clk_en_out) !== 1'h1);
    endtask
    task automatic do_reset(input logic f8, input logic fo);
        divide_by_eight_fuse_in <= f8;
        clock_output_fuse_in <= fo;
        reset_in <= 1'h1;
        repeat (16) @(posedge ref_clk_in);
        check(clock_output_pin_oe_out, fo);
        reset_in <= 1'h0;
        @(posedge ref_clk_in);
    endtask
    // Fuses set opposite, so each reset value must follow its own fuse
    task automatic t_reset();
        do_reset(1'h0, 1'h1);
        bus(1'h0, 4'h0, 8'h0);
        check(rd, 32'h0);
        do_reset(1'h1, 1'h0);
        bus(1'h0, 4'h0, 8'h0);
        check(rd, 32'h3);
        period(1'h1, p);
        check(p, 32'h8);
        $display("reset test done");
    endtask
    // Every legal code through the protected sequence; the shorter of old and new periods bounds the gap from below
    task automatic t_codes();
        prev = 3;
        for (int n = 0; n <= 8; n++) begin
            bus(1'h1, 4'h0, 8'h80);
            bus(1'h1, 4'h0, n[7:0]);
            bus(1'h0, 4'h0, 8'h0);
            check(rd, n);
            period(1'h0, p);
            check(p >= (1 << ((n < prev) ? n : prev)), 32'h1);
            period(1'h0, p);
            check(p, 1 << n);
            bus(1'h0, 4'h4, 8'h0);
            check(rd, n);
            period(1'h1, p);
            check(p, 1 << n);
            prev = n;
        end
        $display("codes test done");
    endtask
    // Writes outside an open window, late, repeated or reserved leave the factor alone
    task automatic t_refuse();
        bus(1'h1, 4'h0, 8'h02);
        bus(1'h0, 4'h0, 8'h0);
        check(rd, 32'h8);
        bus(1'h1, 4'h0, 8'h81);
        bus(1'h1, 4'h0, 8'h02);
        bus(1'h0, 4'h0, 8'h0);
        check(rd, 32'h8);
        bus(1'h1, 4'h0, 8'h80);
        repeat (6) @(posedge ref_clk_in);
        bus(1'h1, 4'h0, 8'h02);
        bus(1'h0, 4'h0, 8'h0);
        check(rd, 32'h8);
        bus(1'h1, 4'h0, 8'h80);
        bus(1'h1, 4'h0, 8'h80);
        bus(1'h1, 4'h0, 8'h02);
        bus(1'h0, 4'h0, 8'h0);
        check(rd, 32'h8);
        bus(1'h1, 4'h0, 8'h80);
        bus(1'h1, 4'h0, 8'h09);
        bus(1'h1, 4'h0, 8'h02);
        bus(1'h0, 4'h0, 8'h0);
        check(rd, 32'h8);
        period(1'h0, p);
        check(p, 32'h100);
        bus(1'h1, 4'h0, 8'h80);
        bus(1'h1, 4'h0, 8'h71);
        bus(1'h0, 4'h0, 8'h0);
        check(rd, 32'h1);
        // Clock enable low freezes the divider and the change-enable window
        bus(1'h1, 4'h0, 8'h80);
        clk_enable_in <= 1'h0;
        repeat (3) @(posedge ref_clk_in);
        p = sys_clk_en_out;
        repeat (8) @(posedge ref_clk_in);
        check(sys_clk_en_out, p);
        clk_enable_in <= 1'h1;
        bus(1'h1, 4'h0, 8'h02);
        bus(1'h0, 4'h0, 8'h0);
        check(rd, 32'h2);
        $display("refuse test done");
    endtask
    task automatic t_pins();
        bus(1'h1, 4'h8, 8'h03);
        for (int s = 0; s < 4; s++) begin
            clock_source_in <= s[1:0];
            repeat (4) @(posedge ref_clk_in);
            check(timer_osc_enable_out, s[1]);
            check(timer_ext_clock_select_out, 32'h1);
        end
        avs_byteenable_in <= 4'h0;
        bus(1'h1, 4'h8, 8'h00);
        avs_byteenable_in <= 4'hF;
        check(timer_ext_clock_select_out, 32'h1);
        bus(1'h1, 4'h8, 8'h00);
        bus(1'h0, 4'hC, 8'h0);
        check(timer_ext_clock_select_out, 32'h0);
        check(rd, 32'h0);
        $display("pins test done");
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        t_reset();
        t_codes();
        t_refuse();
        t_pins();
        print_verdict();
    end
endmodule // tb
